// *** lsv_sequencer.sv ***
// Linear regulator power sequencer with level registers
`include "lsv_defines.svh"
module lsv_sequencer #(
  parameter int EXT_LEAD_CYC = `LSV_EXT_LEAD_CYC,
  parameter int DLY_300_CYC = `LSV_DLY_300_CYC,
  parameter int DLY_10_CYC = `LSV_DLY_10_CYC,
  parameter int START_DLY_CYC = `LSV_START_DLY_CYC,
  parameter logic [2:0] RST_SEQ = `LSV_RST_SEQ,
  parameter logic [3:0] RST_LVL_A = `LSV_RST_LVL_A,
  parameter logic [5:0] RST_LVL_B = `LSV_RST_LVL_B
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_undervoltage_lockout,
  input wire logic i_on_state,
  input wire logic i_step_down_1_en,
  input wire logic i_step_down_2_en,
  input wire logic i_step_down_3_en,
  input wire logic i_step_down_1_ok,
  input wire logic i_step_down_2_ok,
  input wire logic i_step_down_3_ok,
  input wire logic i_step_down_3_enable_pin,
  input wire logic i_step_down_3_level_select_pin,
  input wire logic [5:0] i_step_down_3_level_lo,
  input wire logic [5:0] i_step_down_3_level_hi,
  input wire logic i_ctl_wr,
  input wire logic i_ctl_a_wr,
  input wire logic i_ctl_b_wr,
  input wire logic i_ctl_a_val,
  input wire logic i_ctl_b_val,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_ext_regulator_enable_out,
  output logic o_linear_reg_a_en,
  output logic o_linear_reg_b_en,
  output logic o_linear_reg_a_en_bit,
  output logic o_linear_reg_b_en_bit,
  output logic [3:0] o_linear_reg_a_level,
  output logic [5:0] o_linear_reg_b_level,
  output logic [2:0] o_active_order
);
  localparam int TW = 21;
  localparam int SW = 15;
  logic [2:0] linear_order_select_r;
  logic [3:0] lvl_a_r;
  logic linear_b_follow_r;
  logic [5:0] lvl_b_r;
  lsv_pkg::lsv_order_type order_r;
  lsv_pkg::lsv_state_type state_r;
  logic en_a_r;
  logic en_b_r;
  logic ext_r;
  logic ext_lead_run;
  logic ext_lead_done;
  logic dly_run;
  logic dly_done;
  logic [TW-1:0] dly_count;
  logic want_a;
  logic want_b;
  logic reg_load;
  logic [5:0] s3_level;
  logic [5:0] lvl_b_nxt;

  assign reg_load = i_rst || i_undervoltage_lockout;

  // Register writes; lockout reloads every writable field
  always_ff @(posedge i_core_clk) begin
    if (reg_load) begin
      linear_order_select_r <= RST_SEQ;
      lvl_a_r <= RST_LVL_A;
      linear_b_follow_r <= `LSV_RST_FOLLOW;
      lvl_b_r <= RST_LVL_B;
    end else if (i_reg_wr) begin
      if (i_reg_addr == `LSV_OFF_SEQ_LVL_A) begin
        linear_order_select_r <= i_reg_wdata[`LSV_SEQ_MSB:`LSV_SEQ_LSB];
        lvl_a_r <= i_reg_wdata[`LSV_LVL_A_MSB:0];
      end
      if (i_reg_addr == `LSV_OFF_LVL_B) begin
        linear_b_follow_r <= i_reg_wdata[`LSV_FOLLOW_BIT];
        lvl_b_r <= i_reg_wdata[`LSV_LVL_B_MSB:0];
      end
    end
  end

  // Reserved bits read zero; unmapped addresses read zero
  always_comb begin
    o_reg_rdata = 8'h00;
    if (i_reg_addr == `LSV_OFF_SEQ_LVL_A) begin
      o_reg_rdata = {linear_order_select_r, 1'b0, lvl_a_r};
    end else if (i_reg_addr == `LSV_OFF_LVL_B) begin
      o_reg_rdata = {1'b0, linear_b_follow_r, lvl_b_r};
    end
  end

  // Power state; order captured at power-up so later writes wait for next sequence
  always_ff @(posedge i_core_clk) begin
    if (reg_load) begin
      state_r <= lsv_pkg::LSV_ST_OFF;
      order_r <= lsv_pkg::LSV_ORD_AT_ON;
    end else begin
      case (state_r)
        lsv_pkg::LSV_ST_OFF: begin
          if (i_on_state) begin
            state_r <= lsv_pkg::LSV_ST_RAMP;
            order_r <= lsv_pkg::lsv_order_type'(linear_order_select_r);
          end
        end
        // Host-owned B must not hold the ramp, or A would never reach host control
        lsv_pkg::LSV_ST_RAMP: begin
          if (!i_on_state) begin
            state_r <= lsv_pkg::LSV_ST_OFF;
          end else if (en_a_r && (en_b_r || order_r == lsv_pkg::LSV_ORD_S1_DLY ||
            order_r == lsv_pkg::LSV_ORD_S2_DLY)) begin
            state_r <= lsv_pkg::LSV_ST_ON;
          end
        end
        lsv_pkg::LSV_ST_ON: begin
          if (!i_on_state) begin
            state_r <= lsv_pkg::LSV_ST_OFF;
          end
        end
        default: state_r <= lsv_pkg::LSV_ST_OFF;
      endcase
    end
  end

  // External regulator enable leads; held high through the whole on-state
  always_ff @(posedge i_core_clk) begin
    if (reg_load) begin
      ext_r <= 1'b0;
    end else if (state_r == lsv_pkg::LSV_ST_OFF) begin
      ext_r <= i_on_state && ((linear_order_select_r == 3'h2) ||
        (linear_order_select_r == 3'h7));
    end else if (!i_on_state) begin
      ext_r <= 1'b0;
    end
  end

  assign ext_lead_run = ext_r && (state_r != lsv_pkg::LSV_ST_OFF);

  lsv_timer #(.WIDTH(TW)) u_ext_lead (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_run(ext_lead_run),
    .i_count(TW'(EXT_LEAD_CYC)),
    .o_done(ext_lead_done)
  );

  // One delay timer, started only once the preceding supply reports good
  always_comb begin
    dly_run = 1'b0;
    dly_count = TW'(DLY_300_CYC);
    if (order_r == lsv_pkg::LSV_ORD_S1_DLY) begin
      dly_run = i_step_down_1_en && i_step_down_1_ok;
    end else if (order_r == lsv_pkg::LSV_ORD_S2_DLY) begin
      dly_run = i_step_down_2_en && i_step_down_2_ok;
      dly_count = TW'(DLY_10_CYC);
    end
    dly_run = dly_run && (state_r == lsv_pkg::LSV_ST_RAMP);
  end

  lsv_timer #(.WIDTH(TW)) u_dly (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_run(dly_run),
    .i_count(dly_count),
    .o_done(dly_done)
  );

  // Power-up triggers per order; A auto power-down (orders 001, 010, 100, 101) waits until all three converters are off; order 111: the enable pin drops it
  always_comb begin
    want_a = 1'b0;
    want_b = 1'b0;
    case (order_r)
      lsv_pkg::LSV_ORD_AT_ON: begin
        want_a = 1'b1;
        want_b = 1'b1;
      end
      lsv_pkg::LSV_ORD_AFTER_S3: begin
        want_a = i_step_down_3_en && i_step_down_3_ok;
        want_b = want_a;
      end
      lsv_pkg::LSV_ORD_EXT_S3: begin
        want_a = i_step_down_3_en;
        want_b = ext_lead_done;
      end
      lsv_pkg::LSV_ORD_S1_DLY: begin
        want_a = dly_done;
      end
      lsv_pkg::LSV_ORD_S1_S3: begin
        want_a = i_step_down_1_en && i_step_down_1_ok;
        want_b = i_step_down_3_en;
      end
      lsv_pkg::LSV_ORD_S2_S1: begin
        want_a = i_step_down_2_en;
        want_b = i_step_down_1_en && i_step_down_1_ok;
      end
      lsv_pkg::LSV_ORD_S2_DLY: begin
        want_a = dly_done;
      end
      lsv_pkg::LSV_ORD_EXT_PIN: begin
        want_a = i_step_down_3_enable_pin && i_step_down_3_ok;
        want_b = ext_lead_done;
      end
      default: begin
        want_a = 1'b0;
        want_b = 1'b0;
      end
    endcase
  end

  // Enable bit A: sequencing sets it, host may override in on-state
  always_ff @(posedge i_core_clk) begin
    if (reg_load || !i_on_state) begin
      en_a_r <= 1'b0;
    end else if (order_r == lsv_pkg::LSV_ORD_EXT_PIN && !i_step_down_3_enable_pin &&
      state_r == lsv_pkg::LSV_ST_ON) begin
      en_a_r <= 1'b0;
    end else if (i_ctl_wr && i_ctl_a_wr && state_r == lsv_pkg::LSV_ST_ON) begin
      en_a_r <= i_ctl_a_val;
    end else if (state_r == lsv_pkg::LSV_ST_RAMP && want_a) begin
      en_a_r <= 1'b1;
    end else if (order_r == lsv_pkg::LSV_ORD_EXT_PIN && state_r == lsv_pkg::LSV_ST_ON &&
      want_a) begin
      en_a_r <= 1'b1;
    end else if (state_r == lsv_pkg::LSV_ST_ON && !want_a &&
      order_r != lsv_pkg::LSV_ORD_AT_ON && order_r != lsv_pkg::LSV_ORD_S1_DLY &&
      order_r != lsv_pkg::LSV_ORD_S2_DLY && order_r != lsv_pkg::LSV_ORD_EXT_PIN &&
      !i_step_down_1_en && !i_step_down_2_en && !i_step_down_3_en) begin
      en_a_r <= 1'b0;
    end
  end

  // Enable bit B; host-owned for orders 011 and 110, order 010 drops only at off, 111 also once converters 1 and 2 are off
  always_ff @(posedge i_core_clk) begin
    if (reg_load || !i_on_state) begin
      en_b_r <= 1'b0;
    end else if (i_ctl_wr && i_ctl_b_wr && state_r != lsv_pkg::LSV_ST_OFF &&
      (state_r == lsv_pkg::LSV_ST_ON || order_r == lsv_pkg::LSV_ORD_S1_DLY ||
      order_r == lsv_pkg::LSV_ORD_S2_DLY)) begin
      en_b_r <= i_ctl_b_val;
    end else if (state_r == lsv_pkg::LSV_ST_RAMP && want_b) begin
      en_b_r <= 1'b1;
    end else if (order_r == lsv_pkg::LSV_ORD_EXT_PIN && state_r == lsv_pkg::LSV_ST_ON &&
      !i_step_down_1_en && !i_step_down_2_en) begin
      en_b_r <= 1'b0;
    end
  end

  // Host-owned enables never block the move to the on-state
  // (the ramp completes when the automatic part is done)

  lsv_start_delay #(.WIDTH(SW)) u_start_a (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_en(en_a_r),
    .i_count(SW'(START_DLY_CYC)),
    .o_en(o_linear_reg_a_en)
  );

  lsv_start_delay #(.WIDTH(SW)) u_start_b (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_en(en_b_r),
    .i_count(SW'(START_DLY_CYC)),
    .o_en(o_linear_reg_b_en)
  );

  // Level B: follows the live converter-3 setting when follow is set
  assign s3_level = i_step_down_3_level_select_pin ? i_step_down_3_level_hi :
    i_step_down_3_level_lo;
  assign lvl_b_nxt = linear_b_follow_r ? s3_level : lvl_b_r;

  always_ff @(posedge i_core_clk) begin
    if (reg_load) begin
      o_linear_reg_a_level <= RST_LVL_A;
      o_linear_reg_b_level <= RST_LVL_B;
    end else begin
      o_linear_reg_a_level <= lvl_a_r;
      o_linear_reg_b_level <= lvl_b_nxt;
    end
  end

  assign o_ext_regulator_enable_out = ext_r;
  assign o_linear_reg_a_en_bit = en_a_r;
  assign o_linear_reg_b_en_bit = en_b_r;
  assign o_active_order = order_r;
endmodule

// *** lsv_defines.svh ***
// Register offsets, field positions, reset values and timing counts for the regulator sequencer
`ifndef LSV_DEFINES_SVH
`define LSV_DEFINES_SVH
`define LSV_CLK_MHZ 125
`define LSV_OFF_SEQ_LVL_A 8'h16
`define LSV_OFF_LVL_B 8'h17
`define LSV_SEQ_MSB 7
`define LSV_SEQ_LSB 5
`define LSV_LVL_A_MSB 3
`define LSV_FOLLOW_BIT 6
`define LSV_LVL_B_MSB 5
`define LSV_RST_SEQ 3'h1
`define LSV_RST_LVL_A 4'h9
`define LSV_RST_FOLLOW 1'h0
`define LSV_RST_LVL_B 6'h13
`define LSV_EXT_LEAD_US 1000
`define LSV_EXT_LEAD_CYC ((`LSV_EXT_LEAD_US * `LSV_CLK_MHZ) + 1)
`define LSV_DLY_300_US 300
`define LSV_DLY_300_CYC (`LSV_DLY_300_US * `LSV_CLK_MHZ)
`define LSV_DLY_10_MS 10
`define LSV_DLY_10_CYC (`LSV_DLY_10_MS * 1000 * `LSV_CLK_MHZ)
`define LSV_START_DLY_NS 170000
`define LSV_START_DLY_CYC ((`LSV_START_DLY_NS + 7) / 8)
`endif

// *** lsv_pkg.sv ***
// Types shared by the regulator sequencer
package lsv_pkg;
  typedef enum logic [2:0] {
    LSV_ORD_AT_ON = 3'h0,
    LSV_ORD_AFTER_S3 = 3'h1,
    LSV_ORD_EXT_S3 = 3'h2,
    LSV_ORD_S1_DLY = 3'h3,
    LSV_ORD_S1_S3 = 3'h4,
    LSV_ORD_S2_S1 = 3'h5,
    LSV_ORD_S2_DLY = 3'h6,
    LSV_ORD_EXT_PIN = 3'h7
  } lsv_order_type;
  typedef enum logic [2:0] {
    LSV_ST_OFF = 3'b001,
    LSV_ST_RAMP = 3'b010,
    LSV_ST_ON = 3'b100
  } lsv_state_type;
endpackage

// *** lsv_timer.sv ***
// Retriggerable up counter that reports once a programmed cycle count has elapsed
module lsv_timer #(
  parameter int WIDTH = 21
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_run,
  input wire logic [WIDTH-1:0] i_count,
  output logic o_done
);
  logic [WIDTH-1:0] cnt_r;
  // Dropping i_run restarts the wait, so a lost trigger never leaves a stale count
  always_ff @(posedge i_core_clk) begin
    if (i_rst || !i_run) begin
      cnt_r <= '0;
    end else if (cnt_r != i_count) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end
  assign o_done = i_run && (cnt_r == i_count);
endmodule

// *** lsv_start_delay.sv ***
// Fixed start delay on one regulator enable, released at once on disable
module lsv_start_delay #(
  parameter int WIDTH = 15
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_en,
  input wire logic [WIDTH-1:0] i_count,
  output logic o_en
);
  logic [WIDTH-1:0] cnt_r;
  logic en_r;
  always_ff @(posedge i_core_clk) begin
    if (i_rst || !i_en) begin
      cnt_r <= '0;
    end else if (cnt_r != i_count) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      en_r <= 1'b0;
    end else begin
      en_r <= i_en && (cnt_r == i_count);
    end
  end
  assign o_en = en_r;
endmodule

// *** lsv_conv_model.sv ***
// Behavioural step-down converters that report supply good a while after enable
module lsv_conv_model #(
  parameter int OK_DLY = 5
) (
  input wire logic i_core_clk,
  input wire logic [2:0] i_en,
  output logic [2:0] o_ok
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt [3] = '{0, 0, 0};
  // Good drops at once on disable, as a real converter output collapses
  always @(posedge i_core_clk) begin
    for (int k = 0; k < 3; k++) begin
      cnt[k] <= i_en[k] ? ((cnt[k] < OK_DLY) ? cnt[k] + 1 : cnt[k]) : 0;
      o_ok[k] <= i_en[k] && cnt[k] >= OK_DLY - 1;
    end
  end
endmodule

// *** lsv_sequencer_props.sv ***
// Port-level checks for the regulator sequencer
`include "lsv_defines.svh"
module lsv_sequencer_props #(
  parameter int START_DLY_CYC = `LSV_START_DLY_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_undervoltage_lockout,
  input wire logic i_on_state,
  input wire logic i_step_down_3_level_select_pin,
  input wire logic [5:0] i_step_down_3_level_lo,
  input wire logic [5:0] i_step_down_3_level_hi,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_ext_regulator_enable_out,
  input wire logic o_linear_reg_a_en,
  input wire logic o_linear_reg_b_en,
  input wire logic o_linear_reg_a_en_bit,
  input wire logic o_linear_reg_b_en_bit,
  input wire logic [3:0] o_linear_reg_a_level,
  input wire logic [5:0] o_linear_reg_b_level,
  input wire logic [2:0] o_active_order
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);
  property p_ro_zero;
    !((i_reg_addr == 8'h16 && o_reg_rdata[4]) || (i_reg_addr == 8'h17 && o_reg_rdata[7]));
  endproperty
  a_ro_zero: assert property (p_ro_zero) else $error("reserved bit reads one");
  // The level output is registered behind the field, so the write shows two edges on
  property p_lvl_a;
    i_reg_wr && i_reg_addr == 8'h16 && !i_undervoltage_lockout ##1 !i_undervoltage_lockout
      |=> o_linear_reg_a_level == $past(i_reg_wdata[3:0], 2);
  endproperty
  a_lvl_a: assert property (p_lvl_a) else $error("level a not written");
  // Settled inputs only: the level output is registered one cycle behind
  property p_lvl_b;
    i_reg_addr == 8'h17 && $stable(i_reg_addr) && $stable(o_reg_rdata)
      && $stable(i_step_down_3_level_select_pin) && $stable(i_step_down_3_level_lo)
      && $stable(i_step_down_3_level_hi) |-> o_linear_reg_b_level == (!o_reg_rdata[6] ?
      o_reg_rdata[5:0] : i_step_down_3_level_select_pin ? i_step_down_3_level_hi :
      i_step_down_3_level_lo);
  endproperty
  a_lvl_b: assert property (p_lvl_b) else $error("level b source wrong");
  property p_undervoltage_lockout;
    i_undervoltage_lockout |=> o_linear_reg_a_level == `LSV_RST_LVL_A
      && o_linear_reg_b_level == `LSV_RST_LVL_B && !o_linear_reg_a_en_bit
      && !o_linear_reg_b_en_bit && !o_ext_regulator_enable_out;
  endproperty
  a_undervoltage_lockout: assert property (p_undervoltage_lockout) else $error("lockout did not reload");
  property p_off;
    $fell(i_on_state) |=> !o_linear_reg_a_en_bit && !o_linear_reg_b_en_bit
      ##1 !o_linear_reg_a_en && !o_linear_reg_b_en;
  endproperty
  a_off: assert property (p_off) else $error("regulators stay on at off");
  property p_ext_off;
    !i_on_state |=> !o_ext_regulator_enable_out;
  endproperty
  a_ext_off: assert property (p_ext_off) else $error("ext enable high in off");
  property p_start_dly;
    $rose(o_linear_reg_a_en) |-> $past(o_linear_reg_a_en_bit, START_DLY_CYC + 1)
      && !$past(o_linear_reg_a_en_bit, START_DLY_CYC + 2);
  endproperty
  a_start_dly: assert property (p_start_dly) else $error("a enable not delayed");
  property p_order;
    $rose(i_on_state) && !o_linear_reg_a_en_bit && !o_linear_reg_b_en_bit
      && i_reg_addr == 8'h16 && !i_reg_wr |=> o_active_order == $past(o_reg_rdata[7:5]);
  endproperty
  a_order: assert property (p_order) else $error("order not captured");
  c_ext: cover property ($rose(o_ext_regulator_enable_out));
  c_b_on: cover property ($rose(o_linear_reg_b_en));
  c_a_clr: cover property ($fell(o_linear_reg_a_en_bit) && i_on_state);
endmodule
bind lsv_sequencer lsv_sequencer_props #(.START_DLY_CYC(START_DLY_CYC)) u_props (
  .i_core_clk, .i_rst, .i_undervoltage_lockout, .i_on_state, .i_step_down_3_level_select_pin,
  .i_step_down_3_level_lo, .i_step_down_3_level_hi, .i_reg_wr, .i_reg_addr, .i_reg_wdata,
  .o_reg_rdata, .o_ext_regulator_enable_out, .o_linear_reg_a_en, .o_linear_reg_b_en,
  .o_linear_reg_a_en_bit, .o_linear_reg_b_en_bit, .o_linear_reg_a_level,
  .o_linear_reg_b_level, .o_active_order);

// *** test_ldo_sequencing_voltage_ctrl.sv ***
// Self-checking bench for the regulator sequencer
module test_ldo_sequencing_voltage_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_core_clk = 1'b0, i_rst = 1'b1, i_undervoltage_lockout = 1'b0, i_on_state = 1'b0;
  logic i_step_down_3_enable_pin = 1'b1, i_step_down_3_level_select_pin = 1'b0;
  logic [5:0] i_step_down_3_level_lo = 6'h00, i_step_down_3_level_hi = 6'h00;
  logic i_ctl_wr = 1'b0, i_ctl_a_wr = 1'b0, i_ctl_b_wr = 1'b0, i_ctl_a_val = 1'b0;
  logic i_ctl_b_val = 1'b0, i_reg_wr = 1'b0;
  logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00, o_reg_rdata;
  logic [2:0] s_en = 3'h0, s_ok, o_active_order;
  logic o_ext_regulator_enable_out, o_linear_reg_a_en, o_linear_reg_b_en;
  logic o_linear_reg_a_en_bit, o_linear_reg_b_en_bit;
  logic [3:0] o_linear_reg_a_level;
  logic [5:0] o_linear_reg_b_level;
  logic [31:0] seed = 32'h00007bde;
  logic [31:0] lv;
  logic pa = 1'b0, pb = 1'b0, pe = 1'b0;
  int err_total = 0, checks = 0;
  byte exp_q[$];
  // Expected rise order per code: 1 reg a, 2 reg b, 3 ext enable
  byte seq_t[8][3] = '{'{1, 2, 0}, '{1, 2, 0}, '{3, 2, 1}, '{1, 0, 0},
    '{1, 2, 0}, '{2, 1, 0}, '{1, 0, 0}, '{3, 2, 1}};
  always #4 i_core_clk = ~i_core_clk;
  lsv_sequencer #(.EXT_LEAD_CYC(20), .DLY_300_CYC(10), .DLY_10_CYC(30), .START_DLY_CYC(4)) dut (
    .i_core_clk, .i_rst, .i_undervoltage_lockout, .i_on_state,
    .i_step_down_1_en(s_en[0]), .i_step_down_2_en(s_en[1]), .i_step_down_3_en(s_en[2]),
    .i_step_down_1_ok(s_ok[0]), .i_step_down_2_ok(s_ok[1]), .i_step_down_3_ok(s_ok[2]),
    .i_step_down_3_enable_pin, .i_step_down_3_level_select_pin, .i_step_down_3_level_lo,
    .i_step_down_3_level_hi, .i_ctl_wr, .i_ctl_a_wr, .i_ctl_b_wr, .i_ctl_a_val, .i_ctl_b_val,
    .i_reg_wr, .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .o_ext_regulator_enable_out,
    .o_linear_reg_a_en, .o_linear_reg_b_en, .o_linear_reg_a_en_bit, .o_linear_reg_b_en_bit,
    .o_linear_reg_a_level, .o_linear_reg_b_level, .o_active_order);
  lsv_conv_model u_conv (.i_core_clk, .i_en(s_en), .o_ok(s_ok));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic end_sim();
    if (err_total == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic fail(input string m);
    err_total++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    #1;
    checks++;
    if (got !== exp) fail("value mismatch");
  endtask
  task automatic chk_ev(input byte k);
    checks++;
    if (exp_q.size() > 0 && exp_q[0] == k) exp_q.pop_front();
    else fail("unexpected enable rise");
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_core_clk);
    i_reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_core_clk);
    i_reg_addr <= a;
    #1;
    chk(o_reg_rdata, e);
  endtask
  task automatic ctl(input logic b, input logic v);
    @(posedge i_core_clk);
    i_ctl_wr <= 1'b1;
    i_ctl_a_wr <= !b;
    i_ctl_b_wr <= b;
    i_ctl_a_val <= v;
    i_ctl_b_val <= v;
    @(posedge i_core_clk);
    i_ctl_wr <= 1'b0;
    cyc(10);
  endtask
  task automatic wait_q();
    for (int t = 0; t < 100; t++) begin
      if (exp_q.size() == 0) return;
      @(posedge i_core_clk);
    end
    fail("enable wait ran out");
    end_sim();
  endtask
  // Converters come up one after another, each well after the previous one
  task automatic ramp();
    for (int t = 0; t < 800; t++) begin
      @(posedge i_core_clk);
      s_en <= {t >= 260, t >= 160, t >= 60};
      if (t > 300 && exp_q.size() == 0) return;
    end
    fail("sequence ran out");
    end_sim();
  endtask
  always @(posedge i_core_clk) begin
    #1;
    if (o_ext_regulator_enable_out === 1'b1 && !pe) chk_ev(3);
    if (o_linear_reg_a_en === 1'b1 && !pa) chk_ev(1);
    if (o_linear_reg_b_en === 1'b1 && !pb) chk_ev(2);
    pe = o_ext_regulator_enable_out === 1'b1;
    pa = o_linear_reg_a_en === 1'b1;
    pb = o_linear_reg_b_en === 1'b1;
  end
  initial begin
    repeat (8) @(posedge i_core_clk);
    i_rst <= 1'b0;
    rd(8'h16, 8'h29);
    rd(8'h17, 8'h13);
    rd(8'h18, 8'h00);
    wr(8'h17, 8'hff);
    rd(8'h17, 8'h7f);
    for (int k = 0; k < 4; k++) begin
      lv = rnd();
      @(posedge i_core_clk);
      i_step_down_3_level_lo <= lv[13:8];
      i_step_down_3_level_hi <= lv[21:16];
      i_step_down_3_level_select_pin <= k[0];
      wr(8'h17, {1'b0, k[1], lv[5:0]});
      cyc(3);
      chk({2'h0, o_linear_reg_b_level},
        {2'h0, k[1] ? (k[0] ? lv[21:16] : lv[13:8]) : lv[5:0]});
    end
    for (int c = 0; c < 8; c++) begin
      lv = rnd();
      wr(8'h16, {c[2:0], 1'b1, lv[3:0]});
      rd(8'h16, {c[2:0], 1'b0, lv[3:0]});
      for (int j = 0; j < 3; j++) begin
        if (seq_t[c][j] != 0) exp_q.push_back(seq_t[c][j]);
      end
      @(posedge i_core_clk);
      i_on_state <= 1'b1;
      ramp();
      if (c == 3 || c == 6) exp_q.push_back(8'sd2);
      ctl(1'b1, 1'b1);
      wait_q();
      if (c == 2) begin
        ctl(1'b1, 1'b0);
        chk({7'h00, o_ext_regulator_enable_out}, 8'h01);
      end
      if (c == 7) begin
        i_step_down_3_enable_pin <= 1'b0;
        s_en <= 3'h4;
        cyc(3);
        chk({6'h00, o_linear_reg_a_en_bit, o_linear_reg_b_en_bit}, 8'h00);
      end else begin
        ctl(1'b0, 1'b0);
        exp_q.push_back(8'sd1);
        ctl(1'b0, 1'b1);
        wait_q();
      end
      @(posedge i_core_clk);
      i_on_state <= 1'b0;
      s_en <= 3'h0;
      i_step_down_3_enable_pin <= 1'b1;
      cyc(12);
      chk({5'h00, o_ext_regulator_enable_out, o_linear_reg_a_en, o_linear_reg_b_en},
        8'h00);
    end
    @(posedge i_core_clk);
    i_undervoltage_lockout <= 1'b1;
    @(posedge i_core_clk);
    i_undervoltage_lockout <= 1'b0;
    rd(8'h16, 8'h29);
    rd(8'h17, 8'h13);
    end_sim();
  end
endmodule
